// file: src/debug_comms_channel.sv
// debug comms channel: two transfer words with full flags between an
// external scan debugger and core software on an Avalon-MM slave
// assumes an external tap drives state levels and instruction decodes;
// the test clock is far slower than i_mclk and is sampled, not used as a clock
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - there are two separate transfer words, core-to-host and host-to-core, each with its own full flag.
// - hardware keeps both full flags current and shows them to core software; the scan port sees the core-to-host flag only in comms or monitor mode.
// - with the comms mode flag set through chain 1 the lowest packet bit of the core-to-host word carries status.
// - in comms mode the lowest packet bit is high only while uncollected core data waits.
// - a scan read that returns valid core data clears the core-to-host full flag.
// - while the host-to-core word is still full the status bit reads low and new shifted data is dropped.
// - in monitor mode the transfer words serve only the comms channel.
// - core software reaches the transfer words as debug coprocessor register c5 through the bus.
module debug_comms_channel #(
    parameter int DATA_W  = comms_channel_pkg::DATA_W,
    parameter int ADDR_W  = comms_channel_pkg::ADDR_W,
    parameter int CHAIN_W = comms_channel_pkg::CHAIN_W
) (
    // clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_reset,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]   i_address,
    input  wire logic                i_read,
    input  wire logic                i_write,
    input  wire logic [DATA_W-1:0]   i_writedata,
    input  wire logic [3:0]          i_byteenable,
    output var  logic [DATA_W-1:0]   o_readdata,
    output var  logic                o_waitrequest,
    output var  logic                o_irq,
    // scan link from the external tap
    input  wire logic                i_tck,
    input  wire logic                i_tdi,
    input  wire logic                i_capture_dr,
    input  wire logic                i_shift_dr,
    input  wire logic                i_update_dr,
    input  wire logic                i_ir_intest,
    input  wire logic                i_ir_extest,
    input  wire logic [CHAIN_W-1:0]  i_chain_sel,
    output var  logic                o_tdo,
    // core state
    input  wire logic                i_core_halted,
    input  wire logic                i_monitor_mode
);

    ////////////////////////////////////////////////////////////////////////
    // pin sampling
    ////////////////////////////////////////////////////////////////////////

    logic [comms_channel_pkg::SYN_W-1:0] sync1;
    logic [comms_channel_pkg::SYN_W-1:0] sync2;
    logic                                tck_prev;

    // two flops on every pin; the first is read by the second only
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sync1    <= '0;
            sync2    <= '0;
            tck_prev <= 1'b0;
        end else begin
            sync1    <= {i_tck, i_tdi, i_capture_dr, i_shift_dr, i_update_dr,
                         i_ir_intest, i_ir_extest, i_chain_sel};
            sync2    <= sync1;
            tck_prev <= sync2[comms_channel_pkg::SYN_TCK];
        end
    end

    // decoded link events, one mclk cycle per test clock rising edge
    wire                tck_rise  = sync2[comms_channel_pkg::SYN_TCK] & ~tck_prev;
    wire                tdi_s     = sync2[comms_channel_pkg::SYN_TDI];
    wire                do_cap    = tck_rise & sync2[comms_channel_pkg::SYN_CAP];
    wire                do_shift  = tck_rise & sync2[comms_channel_pkg::SYN_SHIFT];
    wire                do_update = tck_rise & sync2[comms_channel_pkg::SYN_UPDATE];
    wire                ir_intest = sync2[comms_channel_pkg::SYN_INTEST];
    wire                ir_extest = sync2[comms_channel_pkg::SYN_EXTEST];
    wire [CHAIN_W-1:0]  chain     = sync2[CHAIN_W-1:0];
    wire                on_dtr    = (chain == comms_channel_pkg::CHAIN_DTR);
    wire                on_stctl  = (chain == comms_channel_pkg::CHAIN_STCTL);

    ////////////////////////////////////////////////////////////////////////
    // transfer words and flags
    ////////////////////////////////////////////////////////////////////////

    logic [DATA_W-1:0]  core_to_host_word;
    logic [DATA_W-1:0]  host_to_core_word;
    logic               c2h_full;
    logic               h2c_full;
    logic               comms_mode_flag;
    logic [comms_channel_pkg::PACKET_W-1:0] scan_reg;

    // bus handshake: request seen while waitrequest high, done the next edge
    wire                req       = i_read | i_write;
    wire                bus_done  = req & ~o_waitrequest;
    wire                wr_done   = bus_done & i_write;
    wire                rd_done   = bus_done & i_read;
    wire                hit_tx    = (i_address == comms_channel_pkg::OFS_TX_WORD);
    wire                hit_rx    = (i_address == comms_channel_pkg::OFS_RX_WORD);
    wire                hit_ist   = (i_address == comms_channel_pkg::OFS_IRQ_STATUS);
    wire                hit_msk   = (i_address == comms_channel_pkg::OFS_IRQ_MASK);

    // monitor mode keeps the channel live regardless of the flag
    wire                comms_on  = comms_mode_flag | i_monitor_mode;

    // scan events on the data chain
    wire                cap_read  = do_cap & on_dtr & ir_intest;
    wire                cap_poll  = do_cap & on_dtr & ir_extest;
    wire                upd_write = do_update & on_dtr & ir_extest;
    wire                host_take = cap_read & comms_on & c2h_full;
    wire                host_load = upd_write & ~h2c_full;

    // core side effects
    wire [DATA_W-1:0]   wmask     = byte_mask(i_byteenable);
    wire                core_put  = wr_done & hit_tx;
    wire                core_get  = rd_done & hit_rx;

    // expand byte enables to a bit mask
    function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] be);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction : byte_mask

    // merge a write into a stored word under byte enables
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [DATA_W-1:0] m);
        return (old & ~m) | (nw & m);
    endfunction : merge

    // outgoing word and its flag; a core write beats a same-cycle collect
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            core_to_host_word <= comms_channel_pkg::WORD_RESET;
            c2h_full          <= 1'b0;
        end else begin
            if (core_put) begin
                core_to_host_word <= merge(core_to_host_word, i_writedata, wmask);
            end
            if (core_put) begin
                c2h_full <= 1'b1;
            end else if (host_take) begin
                c2h_full <= 1'b0;
            end
        end
    end

    // incoming word and its flag; a load beats a same-cycle core read
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            host_to_core_word <= comms_channel_pkg::WORD_RESET;
            h2c_full          <= 1'b0;
        end else begin
            if (host_load) begin
                host_to_core_word <= scan_reg[comms_channel_pkg::PACKET_W-1:1];
            end
            if (host_load) begin
                h2c_full <= 1'b1;
            end else if (core_get) begin
                h2c_full <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan chains
    ////////////////////////////////////////////////////////////////////////

    // lowest packet bit: valid data for a read in comms or monitor mode (else word bit 0), free slot for a write
    wire                rd_status = comms_on ? c2h_full
                                             : core_to_host_word[0];
    wire                wr_status = ~h2c_full;
    wire [comms_channel_pkg::PACKET_W-1:0] dtr_read_pkt =
        {core_to_host_word, rd_status};
    wire [comms_channel_pkg::PACKET_W-1:0] dtr_poll_pkt =
        {host_to_core_word, wr_status};

    // status and control image; halted bit lets the debugger poll
    wire [comms_channel_pkg::STCTL_W-1:0] debug_status_control_reg =
        stctl_image(comms_mode_flag, i_core_halted);

    function automatic logic [comms_channel_pkg::STCTL_W-1:0] stctl_image(input logic comms,
                                                                           input logic halted);
        logic [comms_channel_pkg::STCTL_W-1:0] v;
        v = '0;
        v[comms_channel_pkg::STCTL_COMMS]  = comms;
        v[comms_channel_pkg::STCTL_HALTED] = halted;
        return v;
    endfunction : stctl_image

    // serial entry point depends on chain length
    wire [comms_channel_pkg::PACKET_W-1:0] shifted_dtr  =
        {tdi_s, scan_reg[comms_channel_pkg::PACKET_W-1:1]};
    wire [comms_channel_pkg::PACKET_W-1:0] shifted_stctl =
        {1'b0, tdi_s, scan_reg[comms_channel_pkg::STCTL_W-1:1]};

    // shared shift register; capture, shift and update follow tck edges
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            scan_reg <= '0;
        end else if (do_cap && on_dtr && ir_intest) begin
            scan_reg <= dtr_read_pkt;
        end else if (cap_poll) begin
            scan_reg <= dtr_poll_pkt;
        end else if (do_cap && on_stctl) begin
            scan_reg <= {1'b0, debug_status_control_reg};
        end else if (do_shift && on_dtr) begin
            scan_reg <= shifted_dtr;
        end else if (do_shift && on_stctl) begin
            scan_reg <= shifted_stctl;
        end
    end

    // comms mode flag written only from chain 1
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            comms_mode_flag <= 1'b0;
        end else if (do_update && on_stctl) begin
            comms_mode_flag <= scan_reg[comms_channel_pkg::STCTL_COMMS];
        end
    end

    // tdo follows the chain bit 0, registered so it is glitch free
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_tdo <= 1'b0;
        end else begin
            o_tdo <= scan_reg[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts
    ////////////////////////////////////////////////////////////////////////

    logic [comms_channel_pkg::IRQ_W-1:0] irq_status;
    logic [comms_channel_pkg::IRQ_W-1:0] irq_mask;

    wire [comms_channel_pkg::IRQ_W-1:0] irq_set = irq_events(host_load, host_take);
    wire [comms_channel_pkg::IRQ_W-1:0] irq_clr =
        (wr_done && hit_ist) ? i_writedata[comms_channel_pkg::IRQ_W-1:0] : '0;

    function automatic logic [comms_channel_pkg::IRQ_W-1:0] irq_events(input logic arrived,
                                                                       input logic taken);
        logic [comms_channel_pkg::IRQ_W-1:0] v;
        v = '0;
        v[comms_channel_pkg::IRQ_RX_ARRIV] = arrived;
        v[comms_channel_pkg::IRQ_TX_TAKEN] = taken;
        return v;
    endfunction : irq_events

    // sticky bits; a new event wins over a write-one clear
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            irq_status <= '0;
            irq_mask   <= comms_channel_pkg::MASK_RESET;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr_done && hit_msk && i_byteenable[0]) begin
                irq_mask <= i_writedata[comms_channel_pkg::IRQ_W-1:0];
            end
            o_irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    ////////////////////////////////////////////////////////////////////////

    // core status view of both flags
    wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, i_monitor_mode, comms_mode_flag,
                                     c2h_full, h2c_full};
    wire [DATA_W-1:0] irq_st_word = {{(DATA_W-comms_channel_pkg::IRQ_W){1'b0}}, irq_status};
    wire [DATA_W-1:0] irq_mk_word = {{(DATA_W-comms_channel_pkg::IRQ_W){1'b0}}, irq_mask};

    // read mux; unmapped offsets read as zero
    logic [DATA_W-1:0] next_readdata;
    always_comb begin
        case (i_address)
            comms_channel_pkg::OFS_TX_WORD:    next_readdata = core_to_host_word;
            comms_channel_pkg::OFS_RX_WORD:    next_readdata = host_to_core_word;
            comms_channel_pkg::OFS_STATUS:     next_readdata = status_word;
            comms_channel_pkg::OFS_IRQ_STATUS: next_readdata = irq_st_word;
            comms_channel_pkg::OFS_IRQ_MASK:   next_readdata = irq_mk_word;
            default:                           next_readdata = '0;
        endcase
    end

    // one wait cycle per access; data registered as waitrequest drops
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= '0;
        end else begin
            o_waitrequest <= ~(req & o_waitrequest);
            if (i_read && o_waitrequest) begin
                o_readdata <= next_readdata;
            end
        end
    end

endmodule : debug_comms_channel

`default_nettype wire

// file: inc/comms_channel_pkg.sv
// package for the debug comms channel: register map, field positions,
// scan chain numbers and packet layout
// assumes a 32-bit Avalon-MM slave on the core side and an external tap
package comms_channel_pkg;

    // widths
    localparam int DATA_W   = 32;
    localparam int PACKET_W = 33;
    localparam int ADDR_W   = 5;
    localparam int CHAIN_W  = 4;

    // byte offsets on the core-side bus (debug coprocessor c5 view)
    localparam logic [ADDR_W-1:0] OFS_TX_WORD    = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_RX_WORD    = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 5'h10;

    // status register fields
    localparam int ST_RX_FULL  = 0;
    localparam int ST_TX_FULL  = 1;
    localparam int ST_COMMS    = 2;
    localparam int ST_MONITOR  = 3;

    // interrupt event bits
    localparam int IRQ_W        = 2;
    localparam int IRQ_RX_ARRIV = 0;
    localparam int IRQ_TX_TAKEN = 1;

    // scan chains
    localparam logic [CHAIN_W-1:0] CHAIN_STCTL = 4'h1;
    localparam logic [CHAIN_W-1:0] CHAIN_DTR   = 4'h5;

    // debug status and control register layout
    localparam int STCTL_W      = 32;
    localparam int STCTL_HALTED = 0;
    localparam int STCTL_COMMS  = 27;

    // reset values
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic [IRQ_W-1:0]  MASK_RESET = 2'h0;

    // sampled pin vector layout
    localparam int SYN_W      = 11;
    localparam int SYN_TCK    = 10;
    localparam int SYN_TDI    = 9;
    localparam int SYN_CAP    = 8;
    localparam int SYN_SHIFT  = 7;
    localparam int SYN_UPDATE = 6;
    localparam int SYN_INTEST = 5;
    localparam int SYN_EXTEST = 4;

endpackage : comms_channel_pkg

// file: testbench/debug_comms_channel_assertions.sv
// port checks for the comms channel: bus handshake, irq, scan output
// bound to the top module, sees only its ports, one clock domain
`timescale 1ns/1ps
`default_nettype none
module debug_comms_channel_assertions #(
    parameter int DATA_W  = comms_channel_pkg::DATA_W,
    parameter int ADDR_W  = comms_channel_pkg::ADDR_W,
    parameter int CHAIN_W = comms_channel_pkg::CHAIN_W
) (
    // clock and reset
    input wire logic              i_mclk,
    input wire logic              i_reset,
    // bus side
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic              i_read,
    input wire logic              i_write,
    input wire logic [DATA_W-1:0] i_writedata,
    input wire logic [DATA_W-1:0] o_readdata,
    input wire logic              o_waitrequest,
    input wire logic              o_irq,
    // scan side
    input wire logic              i_tck,
    input wire logic              o_tdo
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////
    // one wait state, exactly one cycle low, never without a request
    property p_wait_answer;
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
    property p_wait_single;
        $fell(o_waitrequest) |=> o_waitrequest;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("ready held too long");
    property p_wait_cause;
        !o_waitrequest |-> $past(i_read || i_write) && $past(o_waitrequest);
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("ready with no request");
    // read data only moves when a read completes
    property p_hold_data;
        $changed(o_readdata) |-> !o_waitrequest && i_read;
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("read data moved");
    property p_unmapped;
        !o_waitrequest && i_read && i_address > comms_channel_pkg::OFS_IRQ_MASK |-> o_readdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // irq is registered one cycle behind the mask
    property p_mask_quiet;
        !o_waitrequest && i_write && i_address == comms_channel_pkg::OFS_IRQ_MASK
            && i_writedata[1:0] == 2'h0 |-> ##2 !o_irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("masked irq still high");
    // tdo moves a few core cycles after a tck rise, while tck is still high
    property p_tdo_timing;
        $changed(o_tdo) |-> i_tck;
    endproperty
    a_tdo_timing: assert property (p_tdo_timing) else $error("tdo moved with tck low");
    property p_reset_state;
        $fell(i_reset) |-> o_waitrequest && !o_irq && !o_tdo && o_readdata == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs not at reset");
endmodule : debug_comms_channel_assertions
`default_nettype wire

// file: testbench/scan_debugger.sv
// external scan debugger model: tap levels and a gated test clock
// the channel samples tck with its own clock; tck stands low between frames
`timescale 1ns/1ps
`default_nettype none
module scan_debugger (
    // scan pins toward the channel
    output var  logic       o_tck,
    output var  logic       o_tdi,
    output var  logic       o_capture_dr,
    output var  logic       o_shift_dr,
    output var  logic       o_update_dr,
    output var  logic       o_ir_intest,
    output var  logic       o_ir_extest,
    output var  logic [3:0] o_chain_sel,
    // serial data back from the channel
    input  wire logic       i_tdo
);
    // idle levels
    initial begin
        {o_tck, o_tdi, o_capture_dr, o_shift_dr, o_update_dr, o_ir_intest, o_ir_extest} = 7'h00;
        o_chain_sel = 4'h0;
    end
    // one 125 ns test clock period, levels set while tck is low
    task automatic tick();
        #62.5 o_tck = 1'b1;
        #62.5 o_tck = 1'b0;
    endtask : tick
    // capture, n shifts lsb first, update; tdo read before each shift rise
    task automatic scan(input logic [3:0] ch, input logic rd, input int n,
                        input logic [32:0] din, output logic [32:0] dout);
        #3;
        dout = 33'h0_0000_0000;
        o_chain_sel = ch;
        o_ir_intest = rd;
        o_ir_extest = !rd;
        o_capture_dr = 1'b1;
        tick();
        o_capture_dr = 1'b0;
        o_shift_dr = 1'b1;
        for (int i = 0; i < n; i++) begin
            dout[i] = i_tdo;
            o_tdi = din[i];
            tick();
        end
        o_shift_dr = 1'b0;
        o_update_dr = 1'b1;
        tick();
        o_update_dr = 1'b0;
        o_tdi = !o_tdi; // released line shows no stale bit
    endtask : scan
endmodule : scan_debugger
`default_nettype wire

// file: testbench/debug_comms_channel_tb.sv
// self-checking bench: bus tasks on the core side, scan frames on the test side
// assumes the package, design, checker and debugger model are compiled first
`timescale 1ns/1ps
`default_nettype none
module debug_comms_channel_tb;
    localparam logic [4:0]  TXW   = comms_channel_pkg::OFS_TX_WORD;
    localparam logic [4:0]  RXW   = comms_channel_pkg::OFS_RX_WORD;
    localparam logic [4:0]  ST    = comms_channel_pkg::OFS_STATUS;
    localparam logic [4:0]  IRS   = comms_channel_pkg::OFS_IRQ_STATUS;
    localparam logic [4:0]  MSK   = comms_channel_pkg::OFS_IRQ_MASK;
    localparam logic [31:0] COMMS = 32'h1 << comms_channel_pkg::ST_COMMS;
    localparam logic [31:0] TXF   = 32'h1 << comms_channel_pkg::ST_TX_FULL;
    localparam logic [31:0] RXF   = 32'h1 << comms_channel_pkg::ST_RX_FULL;
    localparam logic [31:0] ARV   = 32'h1 << comms_channel_pkg::IRQ_RX_ARRIV;
    localparam logic [31:0] TKN   = 32'h1 << comms_channel_pkg::IRQ_TX_TAKEN;
    logic             i_mclk, i_reset, i_read, i_write, i_core_halted, i_monitor_mode;
    logic [4:0]       i_address;
    logic [31:0]      i_writedata;
    logic [3:0]       i_byteenable;
    logic [32:0]      pkt;
    wire logic [31:0] o_readdata;
    wire logic        o_waitrequest, o_irq, o_tdo, i_tck, i_tdi, i_capture_dr, i_shift_dr;
    wire logic        i_update_dr, i_ir_intest, i_ir_extest;
    wire logic [3:0]  i_chain_sel;
    int               mismatches = 0;
    int               tests_run = 0;
    debug_comms_channel u_debug_comms_channel (.i_mclk(i_mclk), .i_reset(i_reset), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_tck(i_tck), .i_tdi(i_tdi),
        .i_capture_dr(i_capture_dr), .i_shift_dr(i_shift_dr), .i_update_dr(i_update_dr),
        .i_ir_intest(i_ir_intest), .i_ir_extest(i_ir_extest), .i_chain_sel(i_chain_sel), .o_tdo(o_tdo),
        .i_core_halted(i_core_halted), .i_monitor_mode(i_monitor_mode));
    scan_debugger u_scan_debugger (.o_tck(i_tck), .o_tdi(i_tdi), .o_capture_dr(i_capture_dr),
        .o_shift_dr(i_shift_dr), .o_update_dr(i_update_dr), .o_ir_intest(i_ir_intest),
        .o_ir_extest(i_ir_extest), .o_chain_sel(i_chain_sel), .i_tdo(o_tdo));
    ////////////////////////////////////////
    // 100 MHz core clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = !i_mclk;
    end
    // hang guard, far beyond the nine scan frames of the run
    initial begin
        repeat (30000) @(posedge i_mclk);
        mismatches++;
        end_of_test();
    end
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_mclk);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check({1'b0, q}, {1'b0, exp});
    endtask : rdchk
    // frames start just after a core edge so tck never lands on one
    task automatic dbg(input logic [3:0] ch, input logic rd, input logic [32:0] din);
        @(posedge i_mclk);
        u_scan_debugger.scan(ch, rd, (ch == 4'h1) ? 32 : 33, din, pkt);
    endtask : dbg
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////
    // main sequence
    initial begin
        {i_reset, i_read, i_write, i_core_halted, i_monitor_mode} = 5'h12;
        i_address = 5'h00;
        i_writedata = 32'h0000_0000;
        i_byteenable = 4'hF;
        repeat (20) @(posedge i_mclk);
        i_reset <= 1'b0;
        rdchk(MSK, 32'h0000_0000);
        rdchk(ST, 32'h0000_0000);
        wr(RXW, 32'hFFFF_FFFF);
        rdchk(RXW, 32'h0000_0000);
        rdchk(5'h14, 32'h0000_0000);
        dbg(4'h1, 1'b0, 33'h0_0800_0000);
        check(pkt[0], 1'b1);
        rdchk(ST, COMMS);
        wr(MSK, 32'h0000_0003);
        dbg(4'h5, 1'b1, 33'h0);
        check(pkt[0], 1'b0);
        wr(TXW, 32'hA5C3_0F80);
        rdchk(ST, COMMS | TXF);
        dbg(4'h5, 1'b1, 33'h0);
        check(pkt, {32'hA5C3_0F80, 1'b1});
        rdchk(ST, COMMS);
        rdchk(IRS, TKN);
        check(o_irq, 1'b1);
        dbg(4'h5, 1'b1, 33'h0);
        check(pkt[0], 1'b0);
        wr(IRS, TKN);
        rdchk(IRS, 32'h0000_0000);
        check(o_irq, 1'b0);
        dbg(4'h5, 1'b0, {32'h1357_9BDF, 1'b0});
        check(pkt[0], 1'b1);
        rdchk(ST, COMMS | RXF);
        dbg(4'h5, 1'b0, {32'h2468_ACE0, 1'b0});
        check(pkt[0], 1'b0);
        rdchk(RXW, 32'h1357_9BDF);
        rdchk(ST, COMMS);
        rdchk(IRS, ARV);
        wr(IRS, ARV | TKN);
        wr(MSK, 32'h0000_0000);
        dbg(4'h3, 1'b0, {32'hFFFF_FFFF, 1'b0});
        rdchk(ST, COMMS);
        dbg(4'h5, 1'b0, {32'h0F0F_0F0F, 1'b0});
        check(pkt[0], 1'b1);
        rdchk(IRS, ARV);
        check(o_irq, 1'b0);
        rdchk(RXW, 32'h0F0F_0F0F);
        // second reset: comms flag cleared, monitor mode keeps the status bit
        @(posedge i_mclk);
        i_reset <= 1'b1;
        i_monitor_mode <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        wr(TXW, 32'h8000_0002);
        dbg(4'h5, 1'b1, 33'h0);
        check(pkt, {32'h8000_0002, 1'b1});
        end_of_test();
    end
endmodule : debug_comms_channel_tb
bind debug_comms_channel debug_comms_channel_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .CHAIN_W(CHAIN_W))
    u_debug_comms_channel_assertions (.i_mclk(i_mclk), .i_reset(i_reset), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_tck(i_tck), .o_tdo(o_tdo));
`default_nettype wire
